/* File: hdl/cod_decode.sv */
// Functional notes
// - external data store: one byte, two cycles
// - push C0, pop D0: two bytes, two cycles
// - exchanges take one machine cycle
// - AND bit or inverse into carry
// - OR bit or inverse into carry
// - bit to carry one cycle, back two
// - absolute jump/call take top address bits
// - long call and jump: three bytes
// - short relative jump: two bytes, two cycles
// - bit-test branches: three bytes, two cycles
// - indirect jump accumulator plus pointer
// - zero/nonzero accumulator relative jumps
// - compare-and-jump forms: three bytes, two cycles
// - decrement-and-jump: bank two bytes, direct three
// - extended opcode: program store or break
// - bank register from opcode low bits
// - one machine cycle is two clocks
`timescale 1ns/1ns
`default_nettype none
module cod_decode (
  input  wire logic                 clk,                     // system clock
  input  wire logic                 reset,                   // async reset, high
  input  wire logic                 start,                   // begin an instruction
  input  wire logic [7:0]           opcode,                  // first byte
  input  wire logic [7:0]           operand1,                // second byte
  input  wire logic [7:0]           operand2,                // third byte
  input  wire logic [3:0]           extension_opcode_select, // extra opcode choice
  input  wire logic                 branch_cond,             // condition met
  input  wire logic [7:0]           accumulator,             // for indirect jump
  input  wire logic [15:0]          data_pointer_16,         // for indirect jump
  input  wire logic [15:0]          return_addr,             // popped return address
  output logic                      busy,                    // executing
  output logic                      done,                    // instruction ended
  output logic                      insn_known,              // opcode decoded here
  output logic [1:0]                insn_len,                // bytes
  output logic [2:0]                insn_mcycles,            // machine cycles
  output cod_pkg::cod_class_t       insn_class,              // instruction group
  output logic [2:0]                bank_register,           // selected bank register
  output logic                      indirect_pointer_register, // pointer select
  output logic                      branch_taken,            // new target loaded
  output logic                      trap,                    // software break
  output logic [15:0]               pc                       // program counter
);
  import cod_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    cod_state_t state;
    logic [2:0]  count;
    logic [15:0] pc;
    logic [15:0] pc_next;
    logic [1:0]  len;
    logic [2:0]  mc;
    cod_class_t  cls;
    logic [2:0]  bank;
    logic        ptr;
    logic        known;
    logic        taken;
    logic        is_trap;
    logic        done;
    logic        trap;
  } cod_regs_t;

  cod_regs_t   r_reg;
  cod_regs_t   r_next;
  logic [1:0]  d_len;
  logic [2:0]  d_mc;
  cod_class_t  d_cls;
  cod_tgt_t    d_tgt;
  logic        d_uncond;
  logic        d_cond;
  logic        d_known;
  logic [15:0] pc_seq;
  logic [15:0] d_target;

  // ----------------------------------------
  // opcode decode
  // ----------------------------------------
  always_comb begin
    d_len    = LEN_1;
    d_mc     = MC_1;
    d_cls    = CLS_UNKNOWN;
    d_tgt    = TGT_NONE;
    d_uncond = 1'b0;
    d_cond   = 1'b0;
    d_known  = 1'b1;
    if (opcode[4:0] == OPC_ABS_JMP_LOW) begin
      d_len    = LEN_2;
      d_mc     = MC_2;
      d_cls    = CLS_JUMP;
      d_tgt    = TGT_ABS11;
      d_uncond = 1'b1;
    end else if (opcode[4:0] == OPC_ABS_CALL_LOW) begin
      d_len    = LEN_2;
      d_mc     = MC_2;
      d_cls    = CLS_CALL;
      d_tgt    = TGT_ABS11;
      d_uncond = 1'b1;
    end else if (opcode == OPC_EXT_ST_DP || in_pair(opcode, OPC_EXT_ST_PTR)) begin
      d_mc  = MC_2;
      d_cls = CLS_EXT_MOVE;
    end else if (opcode == OPC_PUSH || opcode == OPC_POP) begin
      d_len = LEN_2;
      d_mc  = MC_2;
      d_cls = CLS_STACK;
    end else if (in_bank8(opcode, OPC_XCH_BANK) || in_pair(opcode, OPC_XCH_IND) ||
                 in_pair(opcode, OPC_NIB_XCH_IND)) begin
      d_cls = CLS_EXCHANGE;
    end else if (opcode == OPC_XCH_DIR) begin
      d_len = LEN_2;
      d_cls = CLS_EXCHANGE;
    end else if (opcode == OPC_ANL_C || opcode == OPC_ANL_NC ||
                 opcode == OPC_ORL_C || opcode == OPC_ORL_NC ||
                 opcode == OPC_MOV_BIT_C) begin
      d_len = LEN_2;
      d_mc  = MC_2;
      d_cls = CLS_BIT_LOGIC;
    // bit into carry and bit ops
    end else if (opcode == OPC_MOV_C_BIT || opcode == OPC_CLR_BIT ||
                 opcode == OPC_SETB_BIT || opcode == OPC_CPL_BIT) begin
      d_len = LEN_2;
      d_cls = CLS_BIT_MOVE;
    end else if (opcode == OPC_CLR_C || opcode == OPC_SETB_C || opcode == OPC_CPL_C) begin
      d_cls = CLS_BIT_MOVE;
    end else if (opcode == OPC_LONG_CALL) begin
      d_len    = LEN_3;
      d_mc     = MC_2;
      d_cls    = CLS_CALL;
      d_tgt    = TGT_LONG;
      d_uncond = 1'b1;
    end else if (opcode == OPC_LONG_JMP) begin
      d_len    = LEN_3;
      d_mc     = MC_2;
      d_cls    = CLS_JUMP;
      d_tgt    = TGT_LONG;
      d_uncond = 1'b1;
    end else if (opcode == OPC_SHORT_JMP) begin
      d_len    = LEN_2;
      d_mc     = MC_2;
      d_cls    = CLS_JUMP;
      d_tgt    = TGT_REL1;
      d_uncond = 1'b1;
    end else if (opcode == OPC_JZ || opcode == OPC_JNZ || opcode == OPC_JC ||
                 opcode == OPC_JNC ||
                 in_bank8(opcode, OPC_DEC_JMP_BANK)) begin
      d_len  = LEN_2;
      d_mc   = MC_2;
      d_cls  = CLS_COND_BRANCH;
      d_tgt  = TGT_REL1;
      d_cond = 1'b1;
    end else if (opcode == OPC_JB || opcode == OPC_JNB || opcode == OPC_BIT_JMP_CLR ||
                 opcode == OPC_CMP_JMP_DIR || opcode == OPC_CMP_JMP_IMM ||
                 in_bank8(opcode, OPC_CMP_JMP_BANK) || in_pair(opcode, OPC_CMP_JMP_IND) ||
                 opcode == OPC_DEC_JMP_DIR) begin
      d_len  = LEN_3;
      d_mc   = MC_2;
      d_cls  = CLS_COND_BRANCH;
      d_tgt  = TGT_REL2;
      d_cond = 1'b1;
    end else if (opcode == OPC_JMP_INDIR) begin
      d_mc     = MC_2;
      d_cls    = CLS_JUMP;
      d_tgt    = TGT_INDIR;
      d_uncond = 1'b1;
    end else if (opcode == OPC_RET || opcode == OPC_RETI) begin
      d_mc     = MC_2;
      d_cls    = CLS_RETURN;
      d_tgt    = TGT_RET;
      d_uncond = 1'b1;
    end else if (opcode == OPC_EXTENDED) begin
      if (extension_opcode_select == EXT_SEL_PMEM_STORE) begin
        d_mc  = MC_2;
        d_cls = CLS_PMEM_STORE;
      end else begin
        d_cls = CLS_TRAP;
      end
    end else if (opcode == OPC_NOP) begin
      d_cls = CLS_NOP;
    end else begin
      d_known = 1'b0;
    end
  end

  // ----------------------------------------
  // branch target
  // ----------------------------------------
  assign pc_seq = r_reg.pc + {14'h0000, d_len};

  always_comb begin
    case (d_tgt)
      TGT_ABS11: d_target = {pc_seq[15:11], opcode[7:5], operand1};
      TGT_LONG:  d_target = {operand1, operand2};
      TGT_REL1:  d_target = pc_seq + {{8{operand1[7]}}, operand1};
      TGT_REL2:  d_target = pc_seq + {{8{operand2[7]}}, operand2};
      TGT_INDIR: d_target = data_pointer_16 + {8'h00, accumulator};
      TGT_RET:   d_target = return_addr;
      default:   d_target = pc_seq;
    endcase
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    r_next      = r_reg;
    r_next.done = 1'b0;
    r_next.trap = 1'b0;
    case (r_reg.state)
      ST_IDLE: begin
        if (start) begin
          r_next.state   = ST_EXEC;
          r_next.count   = 3'(int'(d_mc) * CLKS_PER_MCYCLE - 1);
          r_next.len     = d_len;
          r_next.mc      = d_mc;
          r_next.cls     = d_cls;
          r_next.known   = d_known;
          r_next.taken   = d_uncond | (d_cond & branch_cond);
          r_next.is_trap = d_cls == CLS_TRAP;
          r_next.pc_next = (d_uncond | (d_cond & branch_cond)) ? d_target : pc_seq;
          r_next.bank    = opcode[2:0];
          r_next.ptr     = opcode[0];
        end
      end
      ST_EXEC: begin
        if (r_reg.count == COUNT_RESET) begin
          r_next.state = ST_IDLE;
          r_next.pc    = r_reg.pc_next;
          r_next.done  = 1'b1;
          r_next.trap  = r_reg.is_trap;
        end else begin
          r_next.count = r_reg.count - 3'h1;
        end
      end
      default: begin
        r_next.state = ST_IDLE;
      end
    endcase
  end

  // register update
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r_reg <= '{state: ST_IDLE, count: COUNT_RESET, pc: PC_RESET, pc_next: PC_RESET,
                 len: LEN_1, mc: MC_1, cls: CLS_UNKNOWN, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign busy                      = r_reg.state == ST_EXEC;
  assign done                      = r_reg.done;
  assign insn_known                = r_reg.known;
  assign insn_len                  = r_reg.len;
  assign insn_mcycles              = r_reg.mc;
  assign insn_class                = r_reg.cls;
  assign bank_register             = r_reg.bank;
  assign indirect_pointer_register = r_reg.ptr;
  assign branch_taken              = r_reg.taken;
  assign trap                      = r_reg.trap;
  assign pc                        = r_reg.pc;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic go;
  assign go = start && !busy;

  sequence s_exec2;
    busy[*2] ##1 done;
  endsequence

  sequence s_exec4;
    busy[*4] ##1 done;
  endsequence

  property p_ext_store;
    go && (opcode == OPC_EXT_ST_DP || in_pair(opcode, OPC_EXT_ST_PTR)) |=> s_exec4 ##0 insn_len == LEN_1;
  endproperty
  a_ext_store: assert property (p_ext_store) else $error("external store timing wrong");

  property p_stack;
    go && (opcode == OPC_PUSH || opcode == OPC_POP) |=> s_exec4 ##0 insn_len == LEN_2;
  endproperty
  a_stack: assert property (p_stack) else $error("push or pop timing wrong");

  property p_xch;
    go && (in_bank8(opcode, OPC_XCH_BANK) || opcode == OPC_XCH_DIR) |=> s_exec2;
  endproperty
  a_xch: assert property (p_xch) else $error("exchange not one cycle");

  property p_carry;
    go && (opcode == OPC_ANL_NC || opcode == OPC_ORL_C) |=> s_exec4 ##0 insn_mcycles == MC_2;
  endproperty
  a_carry: assert property (p_carry) else $error("carry logic timing wrong");

  // page of the next instruction, then opcode top bits, then low byte
  property p_abs;
    go && (opcode[4:0] == OPC_ABS_JMP_LOW || opcode[4:0] == OPC_ABS_CALL_LOW) |=> s_exec4 ##0
      (pc == {5'(($past(pc, 5) + 16'h0002) >> 11), $past(opcode[7:5], 5), $past(operand1, 5)});
  endproperty
  a_abs: assert property (p_abs) else $error("absolute target page wrong");

  property p_long;
    go && opcode == OPC_LONG_JMP |=> s_exec4 ##0 pc == {$past(operand1, 5), $past(operand2, 5)};
  endproperty
  a_long: assert property (p_long) else $error("long jump target wrong");

  property p_trap;
    go && opcode == OPC_EXTENDED && extension_opcode_select != EXT_SEL_PMEM_STORE |=> s_exec2 ##0 trap;
  endproperty
  a_trap: assert property (p_trap) else $error("break not raised");

  property p_bank;
    go && in_bank8(opcode, OPC_CMP_JMP_BANK) |=> bank_register == $past(opcode[2:0]) && insn_len == LEN_3;
  endproperty
  a_bank: assert property (p_bank) else $error("bank register select wrong");

  property p_mcycle;
    $rose(busy) && insn_mcycles == MC_1 |-> s_exec2;
  endproperty
  a_mcycle: assert property (p_mcycle) else $error("machine cycle not two clocks");

  property p_mcycle2;
    $rose(busy) && insn_mcycles == MC_2 |-> s_exec4;
  endproperty
  a_mcycle2: assert property (p_mcycle2) else $error("two machine cycles not four clocks");

  property p_pc;
    done && !branch_taken |-> pc == $past(pc) + {14'h0000, insn_len};
  endproperty
  a_pc: assert property (p_pc) else $error("sequential advance wrong");
endmodule
`default_nettype wire

/* File: hdl/cod_pkg.sv */
`default_nettype none
package cod_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int          CLKS_PER_MCYCLE = 2;
  localparam logic [1:0]  LEN_1           = 2'h1;
  localparam logic [1:0]  LEN_2           = 2'h2;
  localparam logic [1:0]  LEN_3           = 2'h3;
  localparam logic [2:0]  MC_1            = 3'h1;
  localparam logic [2:0]  MC_2            = 3'h2;
  localparam logic [2:0]  COUNT_RESET     = 3'h0;
  localparam logic [15:0] PC_RESET        = 16'h0000;
  // select value that picks the program memory store; value is arbitrary
  localparam logic [3:0]  EXT_SEL_PMEM_STORE = 4'h1;

  // ----------------------------------------
  // opcodes
  // ----------------------------------------
  localparam logic [7:0] OPC_EXT_ST_PTR   = 8'hF2;
  localparam logic [7:0] OPC_EXT_ST_DP    = 8'hF0;
  localparam logic [7:0] OPC_PUSH         = 8'hC0;
  localparam logic [7:0] OPC_POP          = 8'hD0;
  localparam logic [7:0] OPC_XCH_BANK     = 8'hC8;
  localparam logic [7:0] OPC_XCH_DIR      = 8'hC5;
  localparam logic [7:0] OPC_XCH_IND      = 8'hC6;
  localparam logic [7:0] OPC_NIB_XCH_IND  = 8'hD6;
  localparam logic [7:0] OPC_CLR_C        = 8'hC3;
  localparam logic [7:0] OPC_SETB_C       = 8'hD3;
  localparam logic [7:0] OPC_CPL_C        = 8'hB3;
  localparam logic [7:0] OPC_CLR_BIT      = 8'hC2;
  localparam logic [7:0] OPC_SETB_BIT     = 8'hD2;
  localparam logic [7:0] OPC_CPL_BIT      = 8'hB2;
  localparam logic [7:0] OPC_ANL_C        = 8'h82;
  localparam logic [7:0] OPC_ANL_NC       = 8'hB0;
  localparam logic [7:0] OPC_ORL_C        = 8'h72;
  localparam logic [7:0] OPC_ORL_NC       = 8'hA0;
  localparam logic [7:0] OPC_MOV_C_BIT    = 8'hA2;
  localparam logic [7:0] OPC_MOV_BIT_C    = 8'h92;
  localparam logic [4:0] OPC_ABS_JMP_LOW  = 5'h01;
  localparam logic [4:0] OPC_ABS_CALL_LOW = 5'h11;
  localparam logic [7:0] OPC_LONG_CALL    = 8'h12;
  localparam logic [7:0] OPC_LONG_JMP     = 8'h02;
  localparam logic [7:0] OPC_RET          = 8'h22;
  localparam logic [7:0] OPC_RETI         = 8'h32;
  localparam logic [7:0] OPC_SHORT_JMP    = 8'h80;
  localparam logic [7:0] OPC_JC           = 8'h40;
  localparam logic [7:0] OPC_JNC          = 8'h50;
  localparam logic [7:0] OPC_JB           = 8'h20;
  localparam logic [7:0] OPC_JNB          = 8'h30;
  localparam logic [7:0] OPC_BIT_JMP_CLR  = 8'h10;
  localparam logic [7:0] OPC_JMP_INDIR    = 8'h73;
  localparam logic [7:0] OPC_JZ           = 8'h60;
  localparam logic [7:0] OPC_JNZ          = 8'h70;
  localparam logic [7:0] OPC_CMP_JMP_DIR  = 8'hB5;
  localparam logic [7:0] OPC_CMP_JMP_IMM  = 8'hB4;
  localparam logic [7:0] OPC_CMP_JMP_BANK = 8'hB8;
  localparam logic [7:0] OPC_CMP_JMP_IND  = 8'hB6;
  localparam logic [7:0] OPC_DEC_JMP_BANK = 8'hD8;
  localparam logic [7:0] OPC_DEC_JMP_DIR  = 8'hD5;
  localparam logic [7:0] OPC_EXTENDED     = 8'hA5;
  localparam logic [7:0] OPC_NOP          = 8'h00;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } cod_state_t;

  typedef enum logic [3:0] {
    CLS_UNKNOWN     = 4'h0,
    CLS_EXT_MOVE    = 4'h1,
    CLS_STACK       = 4'h2,
    CLS_EXCHANGE    = 4'h3,
    CLS_BIT_LOGIC   = 4'h4,
    CLS_BIT_MOVE    = 4'h5,
    CLS_JUMP        = 4'h6,
    CLS_CALL        = 4'h7,
    CLS_RETURN      = 4'h8,
    CLS_COND_BRANCH = 4'h9,
    CLS_PMEM_STORE  = 4'hA,
    CLS_TRAP        = 4'hB,
    CLS_NOP         = 4'hC
  } cod_class_t;

  typedef enum logic [2:0] {
    TGT_NONE  = 3'h0,
    TGT_ABS11 = 3'h1,
    TGT_LONG  = 3'h2,
    TGT_REL1  = 3'h3,
    TGT_REL2  = 3'h4,
    TGT_INDIR = 3'h5,
    TGT_RET   = 3'h6
  } cod_tgt_t;

  // block of eight codes sharing the top five bits
  function automatic logic in_bank8(input logic [7:0] op, input logic [7:0] base);
    return op[7:3] == base[7:3];
  endfunction

  // pair of codes sharing the top seven bits
  function automatic logic in_pair(input logic [7:0] op, input logic [7:0] base);
    return op[7:1] == base[7:1];
  endfunction
endpackage
`default_nettype wire

/* File: tb/tb_cod_decode.sv */
`timescale 1ns/1ns
`default_nettype none
// compare two values, count it, report a mismatch
`define CHECK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin bad_count++; $display("wrong value at %0t ns: got %h expected %h", $time, got, exp); end end
module tb_cod_decode;
  import cod_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int TIMEOUT_CYCLES = 5000;
  // entries are opcode, byte length, machine cycles
  localparam logic [15:0] MOVE_TAB [18] = '{16'hF212, 16'hF312, 16'hF012, 16'hC022, 16'hD022, 16'hC521,
    16'hC611, 16'hC711, 16'hD611, 16'hD711, 16'hC811, 16'hC911, 16'hCA11, 16'hCB11, 16'hCC11, 16'hCD11,
    16'hCE11, 16'hCF11};
  localparam logic [15:0] BIT_TAB [13] = '{16'h8222, 16'hB022, 16'h7222, 16'hA022, 16'hA221, 16'h9222,
    16'hC311, 16'hD311, 16'hB311, 16'hC221, 16'hD221, 16'hB221, 16'h0011};
  localparam logic [7:0] COND_OPS [25] = '{8'h20, 8'h30, 8'h10, 8'h60, 8'h70, 8'h40, 8'h50, 8'hB5, 8'hB4,
    8'hB6, 8'hB7, 8'hD5, 8'hB8, 8'hB9, 8'hBA, 8'hBB, 8'hBC, 8'hBD, 8'hBE, 8'hBF, 8'hD8, 8'hD9, 8'hDC, 8'hDF,
    8'hDA};
  logic        clk;
  logic        reset;
  logic        start;
  logic [7:0]  opcode;
  logic [7:0]  operand1;
  logic [7:0]  operand2;
  logic [3:0]  extension_opcode_select;
  logic        branch_cond;
  logic [7:0]  accumulator;
  logic [15:0] data_pointer_16;
  logic [15:0] return_addr;
  logic        busy;
  logic        done;
  logic        insn_known;
  logic [1:0]  insn_len;
  logic [2:0]  insn_mcycles;
  cod_class_t  insn_class;
  logic [2:0]  bank_register;
  logic        indirect_pointer_register;
  logic        branch_taken;
  logic        trap;
  logic [15:0] pc;
  logic [15:0] cur_pc;
  int          bad_count;
  int          cmp_count;
  int          cycles;

  cod_decode DUT (
    .clk                       (clk),
    .reset                     (reset),
    .start                     (start),
    .opcode                    (opcode),
    .operand1                  (operand1),
    .operand2                  (operand2),
    .extension_opcode_select   (extension_opcode_select),
    .branch_cond               (branch_cond),
    .accumulator               (accumulator),
    .data_pointer_16           (data_pointer_16),
    .return_addr               (return_addr),
    .busy                      (busy),
    .done                      (done),
    .insn_known                (insn_known),
    .insn_len                  (insn_len),
    .insn_mcycles              (insn_mcycles),
    .insn_class                (insn_class),
    .bank_register             (bank_register),
    .indirect_pointer_register (indirect_pointer_register),
    .branch_taken              (branch_taken),
    .trap                      (trap),
    .pc                        (pc)
  );

  // ----------------------------------------
  // clock and watchdog
  // ----------------------------------------
  // free running 4 ns clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == TIMEOUT_CYCLES) begin
      bad_count++;
      complete_run();
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // edges until done, sampled after each edge settles
  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 20);
  endtask

  function automatic logic [15:0] rel(input logic [1:0] len, input logic [7:0] d);
    return cur_pc + 16'(len) + {{8{d[7]}}, d};
  endfunction

  function automatic logic [15:0] abs11(input logic [7:0] op, input logic [7:0] lo);
    logic [15:0] nx;
    nx = cur_pc + 16'h0002;
    return {nx[15:11], op[7:5], lo};
  endfunction

  // run one instruction and judge its length, timing and new counter
  task automatic exec(input logic [7:0] op, input logic [7:0] o1, input logic [7:0] o2, input logic [3:0] sel,
                      input logic cond, input logic [1:0] len, input logic [2:0] mc, input logic tk,
                      input logic [15:0] tgt);
    int          n;
    logic [15:0] exp_pc;
    @(posedge clk);
    start <= 1'b1;
    opcode <= op;
    operand1 <= o1;
    operand2 <= o2;
    extension_opcode_select <= sel;
    branch_cond <= cond;
    @(posedge clk);
    start <= 1'b0;
    wait_done(n);
    exp_pc = tk ? tgt : cur_pc + 16'(len);
    `CHECK(n, 2 * int'(mc))
    `CHECK(insn_len, len)
    `CHECK(insn_mcycles, mc)
    `CHECK(branch_taken, tk)
    `CHECK(bank_register, op[2:0])
    `CHECK(indirect_pointer_register, op[0])
    `CHECK(insn_known, 1'b1)
    `CHECK(trap, op == OPC_EXTENDED && sel != EXT_SEL_PMEM_STORE)
    `CHECK(pc, exp_pc)
    cur_pc = exp_pc;
  endtask

  task automatic run_table(input logic [15:0] e);
    exec(e[15:8], 8'h11, 8'h22, 4'h0, 1'b0, e[5:4], e[2:0], 1'b0, 16'h0000);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_reset();
    `CHECK(busy, 1'b0)
    `CHECK(pc, PC_RESET)
    $display("reset test finished");
  endtask

  task automatic test_data_moves();
    foreach (MOVE_TAB[i]) run_table(MOVE_TAB[i]);
    $display("data move test finished");
  endtask

  task automatic test_bit_ops();
    foreach (BIT_TAB[i]) run_table(BIT_TAB[i]);
    $display("bit logic test finished");
  endtask

  task automatic test_long_short();
    exec(8'h02, 8'h5A, 8'h00, 4'h0, 1'b0, LEN_3, MC_2, 1'b1, 16'h5A00);
    exec(8'h12, 8'h12, 8'h34, 4'h0, 1'b0, LEN_3, MC_2, 1'b1, 16'h1234);
    `CHECK(insn_class, CLS_CALL)
    exec(8'h80, 8'hFE, 8'h00, 4'h0, 1'b0, LEN_2, MC_2, 1'b1, rel(LEN_2, 8'hFE));
    exec(8'h80, 8'h7F, 8'h00, 4'h0, 1'b0, LEN_2, MC_2, 1'b1, rel(LEN_2, 8'h7F));
    $display("long and short jump test finished");
  endtask

  task automatic test_absolute();
    logic [7:0] op;
    exec(8'h02, 8'hD7, 8'h00, 4'h0, 1'b0, LEN_3, MC_2, 1'b1, 16'hD700);
    for (int k = 0; k < 8; k++) begin
      op = {3'(k), 5'h01};
      exec(op, 8'h3C, 8'h00, 4'h0, 1'b0, LEN_2, MC_2, 1'b1, abs11(op, 8'h3C));
      op = {3'(k), 5'h11};
      exec(op, 8'hC3, 8'h00, 4'h0, 1'b0, LEN_2, MC_2, 1'b1, abs11(op, 8'hC3));
    end
    $display("absolute branch test finished");
  endtask

  task automatic test_conditional();
    logic [7:0] op;
    logic [1:0] len;
    for (int c = 0; c < 2; c++) begin
      foreach (COND_OPS[i]) begin
        op = COND_OPS[i];
        len = (op == 8'h60 || op == 8'h70 || op == 8'h40 || op == 8'h50 || op[7:3] == 5'h1B) ? LEN_2 : LEN_3;
        exec(op, 8'h05, 8'hF0, 4'h0, 1'(c), len, MC_2, 1'(c), rel(len, len == LEN_2 ? 8'h05 : 8'hF0));
      end
    end
    $display("conditional branch test finished");
  endtask

  task automatic test_indirect();
    @(posedge clk);
    accumulator <= 8'hFF;
    data_pointer_16 <= 16'h10F0;
    return_addr <= 16'hBEEF;
    exec(8'h73, 8'h00, 8'h00, 4'h0, 1'b0, LEN_1, MC_2, 1'b1, 16'h11EF);
    `CHECK(insn_class, CLS_JUMP)
    exec(8'h22, 8'h00, 8'h00, 4'h0, 1'b0, LEN_1, MC_2, 1'b1, 16'hBEEF);
    exec(8'h32, 8'h00, 8'h00, 4'h0, 1'b0, LEN_1, MC_2, 1'b1, 16'hBEEF);
    $display("indirect jump test finished");
  endtask

  task automatic test_extended();
    exec(8'hA5, 8'h00, 8'h00, EXT_SEL_PMEM_STORE, 1'b0, LEN_1, MC_2, 1'b0, 16'h0000);
    `CHECK(insn_class, CLS_PMEM_STORE)
    exec(8'hA5, 8'h00, 8'h00, ~EXT_SEL_PMEM_STORE, 1'b0, LEN_1, MC_1, 1'b0, 16'h0000);
    `CHECK(insn_class, CLS_TRAP)
    $display("extended opcode test finished");
  endtask

  // start held high while busy is ignored, then taken in the done cycle
  task automatic test_refused();
    int n;
    @(posedge clk);
    start <= 1'b1;
    opcode <= 8'h02;
    operand1 <= 8'h44;
    operand2 <= 8'h10;
    @(posedge clk);
    opcode <= 8'h00;
    wait_done(n);
    `CHECK(n, 4)
    `CHECK(pc, 16'h4410)
    @(posedge clk);
    start <= 1'b0;
    #1;
    wait_done(n);
    `CHECK(n, 2)
    `CHECK(pc, 16'h4411)
    cur_pc = 16'h4411;
    $display("refused start test finished");
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    bad_count = 0;
    cmp_count = 0;
    cycles = 0;
    cur_pc = PC_RESET;
    reset = 1'b1;
    start = 1'b0;
    opcode = 8'h00;
    operand1 = 8'h00;
    operand2 = 8'h00;
    extension_opcode_select = 4'h0;
    branch_cond = 1'b0;
    accumulator = 8'h00;
    data_pointer_16 = 16'h0000;
    return_addr = 16'h0000;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    #1;
    test_reset();
    test_data_moves();
    test_bit_ops();
    test_long_short();
    test_absolute();
    test_conditional();
    test_indirect();
    test_extended();
    test_refused();
    complete_run();
  end
endmodule
`default_nettype wire
